// ===== src/cpm_pkg.sv
// shared constants and types of the processor clock and power management interface
package cpm_pkg;

  // sleep sequencer states, one-hot
  typedef enum logic [3:0] {
    CPM_RUN   = 4'h1,
    CPM_DRAIN = 4'h2,
    CPM_SLEEP = 4'h4,
    CPM_WAKE  = 4'h8
  } cpm_state_t;

  // default widths of timers
  localparam int CPM_TB_W = 64;
  localparam int CPM_PIT_W = 32;

  // time-base bits watched by the fixed interval timer, picked by a 2-bit select
  localparam int CPM_FIT_BITS [4] = '{9, 13, 17, 21};
  // time-base bits watched by the watchdog, picked by a 2-bit select
  localparam int CPM_WDT_BITS [4] = '{17, 21, 25, 29};

  // number of sampled foreign clocks
  localparam int CPM_NCLK = 4;
  // positions of the foreign clocks in the sampled vector
  localparam int CPM_CK_LB = 0;
  localparam int CPM_CK_REG = 1;
  localparam int CPM_CK_COP = 2;
  localparam int CPM_CK_OCM = 3;

  // number of synchronised asynchronous event pins
  localparam int CPM_NPIN = 3;
  // positions of event pins in the synchronised vector
  localparam int CPM_PIN_EXT = 0;
  localparam int CPM_PIN_CRIT = 1;
  localparam int CPM_PIN_HALT = 2;

  // timer status clear positions
  localparam int CPM_CLR_PIT = 0;
  localparam int CPM_CLR_FIT = 1;
  localparam int CPM_CLR_WDT = 2;

  // reset values
  localparam logic CPM_MSR_RST = 1'b0;

endpackage

// ===== src/cpm_sync.sv
// two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module cpm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // refuse an empty vector
  if (W < 1) begin : g_chk
    $error("cpm_sync width must be at least one");
  end

  // first stage, read only by the second
  logic [W-1:0] meta;

  // two flops per bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// ===== src/cpm_timers.sv
// timer zone: time base, interval timer, fixed interval timer and watchdog
`timescale 1ns/1ns
`default_nettype none
module cpm_timers #(
  parameter int TB_W = cpm_pkg::CPM_TB_W,
  parameter int PIT_W = cpm_pkg::CPM_PIT_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic advance,
  input wire logic pit_load,
  input wire logic [PIT_W-1:0] pit_value,
  input wire logic pit_auto,
  input wire logic [1:0] fit_sel,
  input wire logic [1:0] wdt_sel,
  input wire logic wdt_rst_en,
  input wire logic [2:0] status_clr,
  output logic [TB_W-1:0] time_base,
  output logic [PIT_W-1:0] pit_count,
  output logic pit_irq,
  output logic fit_irq,
  output logic wdt_irq,
  output logic wdt_reset_req
);

  // selected bits must exist in the time base
  if (TB_W <= cpm_pkg::CPM_WDT_BITS[3] || PIT_W < 2) begin : g_chk
    $error("cpm_timers widths too small for the selected bits");
  end

  // incremented time base, used to spot 0 to 1 transitions
  logic [TB_W-1:0] tb_inc;
  // reload value for auto-reload mode
  logic [PIT_W-1:0] pit_reload;
  // single-cycle timer events
  logic pit_hit;
  logic fit_hit;
  logic wdt_hit;

  assign tb_inc = time_base + 1'b1;
  assign pit_hit = advance && !pit_load && (pit_count == PIT_W'(1));
  assign fit_hit = advance && !time_base[cpm_pkg::CPM_FIT_BITS[fit_sel]]
                   && tb_inc[cpm_pkg::CPM_FIT_BITS[fit_sel]];
  assign wdt_hit = advance && !time_base[cpm_pkg::CPM_WDT_BITS[wdt_sel]]
                   && tb_inc[cpm_pkg::CPM_WDT_BITS[wdt_sel]];

  // time base counts up on each enabled tick
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      time_base <= '0;
    end else if (advance) begin
      time_base <= tb_inc; // RULE12
    end
  end

  // interval timer counts down to zero, optional reload
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pit_count <= '0;
      pit_reload <= '0;
    end else if (pit_load) begin
      pit_count <= pit_value;
      pit_reload <= pit_value;
    end else if (pit_hit && pit_auto) begin
      pit_count <= pit_reload;
    end else if (advance && pit_count != '0) begin
      pit_count <= pit_count - 1'b1; // RULE12
    end
  end

  // sticky timer status; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pit_irq <= 1'b0;
      fit_irq <= 1'b0;
    end else begin
      pit_irq <= pit_hit || (pit_irq && !status_clr[cpm_pkg::CPM_CLR_PIT]);
      fit_irq <= fit_hit || (fit_irq && !status_clr[cpm_pkg::CPM_CLR_FIT]);
    end
  end

  // watchdog: first timeout interrupts, second one while pending asks reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_irq <= 1'b0;
      wdt_reset_req <= 1'b0;
    end else begin
      wdt_irq <= wdt_hit || (wdt_irq && !status_clr[cpm_pkg::CPM_CLR_WDT]);
      if (wdt_hit && wdt_irq && wdt_rst_en) begin
        wdt_reset_req <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== src/cpm_clk_pwr_if.sv
// processor-side clock zones, sleep sequencing and status outputs
//
// Behaviour
// RULE1 - core logic advances only when core enable high
// RULE2 - timers have own enable, run while core stopped
// RULE3 - debug-port zone enable stays high, never gated
// RULE4 - stopped main clock held high by partner
// RULE5 - main clock drives core and timers only
// RULE6 - partner wakes on timer irq or watchdog
// RULE7 - partner wakes on outside chip reset request
// RULE8 - partner wakes on enabled external interrupt
// RULE9 - partner wakes on debug halt request
// RULE10 - unused zone enables and tick tied high
// RULE11 - clock-inactive status latched for debug, tie low
// RULE12 - timers step on each active tick cycle
// RULE13 - bypass selects legacy local bus synchroniser
// RULE14 - register bus synchronised to its own clock
// RULE15 - coprocessor interface clocked by its own clock
// RULE16 - status outputs mirror both interrupt enable bits
// RULE17 - timer irq output while timer request pending
// RULE18 - watchdog reset request output when requested
// RULE19 - sleep request output when core asks sleep
// RULE20 - memory controllers use their own clock
// RULE21 - local bus logic follows local bus clock
// RULE22 - wake drops status one cycle before sleep
// RULE23 - sleep request only after prior work drains
// RULE24 - partner flags clock-inactive whenever it sleeps core
// RULE25 - partner registers status before gating clocks
`timescale 1ns/1ns
`default_nettype none
module cpm_clk_pwr_if #(
  parameter int TB_W = cpm_pkg::CPM_TB_W,
  parameter int PIT_W = cpm_pkg::CPM_PIT_W
) (
  input wire logic clk, // main processor clock, 10 MHz
  input wire logic arst_n,
  input wire logic core_zone_clk_en,
  input wire logic timer_zone_clk_en,
  input wire logic test_port_zone_clk_en,
  input wire logic core_clk_inactive_in,
  input wire logic timer_tick_in,
  input wire logic sync_bypass_in,
  input wire logic local_bus_clk,
  input wire logic reg_bus_clk,
  input wire logic coproc_if_clk,
  input wire logic ocm_clk,
  input wire logic ext_int_in,
  input wire logic crit_int_in,
  input wire logic debug_halt_in,
  input wire logic msr_wr,
  input wire logic msr_wr_ee,
  input wire logic msr_wr_ce,
  input wire logic msr_wr_we,
  input wire logic core_busy,
  input wire logic pit_load,
  input wire logic [PIT_W-1:0] pit_value,
  input wire logic pit_auto,
  input wire logic [1:0] fit_sel,
  input wire logic [1:0] wdt_sel,
  input wire logic wdt_rst_en,
  input wire logic [2:0] timer_status_clr,
  output logic noncrit_int_en_out,
  output logic crit_int_en_out,
  output logic timer_irq_out,
  output logic watchdog_reset_req_out,
  output logic sleep_req_out,
  output logic local_bus_tick,
  output logic reg_bus_tick,
  output logic coproc_tick,
  output logic ocm_tick,
  output logic debug_sleep_seen,
  output logic [TB_W-1:0] time_base,
  output logic [PIT_W-1:0] pit_count
);

  // sleep sequencer state
  cpm_pkg::cpm_state_t state;
  cpm_pkg::cpm_state_t next_state;
  // state seen after this edge, frozen while the core zone is off
  cpm_pkg::cpm_state_t eff_next;
  // machine-state bits
  logic noncrit_int_enable_bit;
  logic crit_int_enable_bit;
  logic wait_state_enable_bit;
  // synchronised foreign clocks and their previous value
  logic [cpm_pkg::CPM_NCLK-1:0] fclk_s;
  logic [cpm_pkg::CPM_NCLK-1:0] fclk_d;
  logic [cpm_pkg::CPM_NCLK-1:0] fclk_rise;
  logic [cpm_pkg::CPM_NCLK-1:0] fclk_tick;
  // extra stage of the full local bus resynchroniser
  logic lb_rise_d;
  // synchronised event pins
  logic [cpm_pkg::CPM_NPIN-1:0] pin_s;
  // timer events
  logic pit_irq;
  logic fit_irq;
  logic wdt_irq;
  logic wdt_req;
  logic timer_irq_any;
  logic wake_cause;
  logic wake_go;

  // foreign clocks and pins come from other domains
  cpm_sync #(
    .W(cpm_pkg::CPM_NCLK)
  ) u_clk_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({ocm_clk, coproc_if_clk, reg_bus_clk, local_bus_clk}),
    .sync_out(fclk_s)
  );

  cpm_sync #(
    .W(cpm_pkg::CPM_NPIN)
  ) u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({debug_halt_in, crit_int_in, ext_int_in}),
    .sync_out(pin_s)
  );

  // timer zone, stepped by its own enable and tick only
  cpm_timers #(
    .TB_W(TB_W),
    .PIT_W(PIT_W)
  ) u_timers (
    .clk(clk),
    .arst_n(arst_n),
    .advance(timer_zone_clk_en && timer_tick_in), // RULE2 RULE5 RULE12
    .pit_load(pit_load),
    .pit_value(pit_value),
    .pit_auto(pit_auto),
    .fit_sel(fit_sel),
    .wdt_sel(wdt_sel),
    .wdt_rst_en(wdt_rst_en),
    .status_clr(timer_status_clr),
    .time_base(time_base),
    .pit_count(pit_count),
    .pit_irq(pit_irq),
    .fit_irq(fit_irq),
    .wdt_irq(wdt_irq),
    .wdt_reset_req(wdt_req)
  );

  // timer interrupt is the or of all three timers
  assign timer_irq_any = pit_irq || fit_irq || wdt_irq;
  // causes that bring the core out of sleep once its clock is back
  assign wake_cause = timer_irq_any || wdt_req
                      || (pin_s[cpm_pkg::CPM_PIN_EXT] && noncrit_int_enable_bit)
                      || (pin_s[cpm_pkg::CPM_PIN_CRIT] && crit_int_enable_bit)
                      || pin_s[cpm_pkg::CPM_PIN_HALT]; // RULE6 RULE8 RULE9
  assign wake_go = core_zone_clk_en && (state == cpm_pkg::CPM_SLEEP) && wake_cause;
  assign eff_next = core_zone_clk_en ? next_state : state; // RULE1

  // sleep sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      cpm_pkg::CPM_RUN: begin
        // wait-state bit set: drain outstanding work first
        if (wait_state_enable_bit) begin
          next_state = cpm_pkg::CPM_DRAIN;
        end
      end
      cpm_pkg::CPM_DRAIN: begin
        // all prior instructions and accesses done
        if (!core_busy) begin
          next_state = cpm_pkg::CPM_SLEEP; // RULE23
        end
      end
      cpm_pkg::CPM_SLEEP: begin
        if (wake_cause) begin
          next_state = cpm_pkg::CPM_WAKE;
        end
      end
      cpm_pkg::CPM_WAKE: begin
        // one cycle with status dropped, sleep request still up
        next_state = cpm_pkg::CPM_RUN; // RULE22
      end
      default: begin
        next_state = cpm_pkg::CPM_RUN;
      end
    endcase
  end

  // state register, held while the core zone is stopped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= cpm_pkg::CPM_RUN;
    end else if (core_zone_clk_en) begin
      state <= next_state; // RULE1
    end
  end

  // machine-state bits; wake clears all three as the interrupt is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      noncrit_int_enable_bit <= cpm_pkg::CPM_MSR_RST;
      crit_int_enable_bit <= cpm_pkg::CPM_MSR_RST;
      wait_state_enable_bit <= cpm_pkg::CPM_MSR_RST;
    end else if (core_zone_clk_en) begin
      if (wake_go) begin
        noncrit_int_enable_bit <= 1'b0; // RULE22
        crit_int_enable_bit <= 1'b0;
        wait_state_enable_bit <= 1'b0;
      end else if (msr_wr && state == cpm_pkg::CPM_RUN) begin
        noncrit_int_enable_bit <= msr_wr_ee;
        crit_int_enable_bit <= msr_wr_ce;
        wait_state_enable_bit <= msr_wr_we;
      end
    end
  end

  // enable bits go straight out
  assign noncrit_int_en_out = noncrit_int_enable_bit; // RULE16
  assign crit_int_en_out = crit_int_enable_bit; // RULE16
  assign watchdog_reset_req_out = wdt_req; // RULE18

  // sleep request and timer irq status, the timer irq masked in the wake cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_req_out <= 1'b0;
      timer_irq_out <= 1'b0;
    end else begin
      sleep_req_out <= (eff_next == cpm_pkg::CPM_SLEEP)
                       || (eff_next == cpm_pkg::CPM_WAKE); // RULE19 RULE23
      timer_irq_out <= timer_irq_any && (eff_next != cpm_pkg::CPM_WAKE); // RULE17 RULE22
    end
  end

  // debug-port zone latch, driven only by its own enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      debug_sleep_seen <= 1'b0;
    end else if (test_port_zone_clk_en) begin
      debug_sleep_seen <= core_clk_inactive_in; // RULE3 RULE11 RULE24
    end
  end

  // rising edges of the foreign clocks become one-cycle ticks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fclk_d <= '0;
      lb_rise_d <= 1'b0;
    end else begin
      fclk_d <= fclk_s;
      lb_rise_d <= fclk_rise[cpm_pkg::CPM_CK_LB];
    end
  end

  // per-clock edge and tick
  for (genvar i = 0; i < cpm_pkg::CPM_NCLK; i++) begin : g_fclk
    assign fclk_rise[i] = fclk_s[i] && !fclk_d[i];
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        fclk_tick[i] <= 1'b0;
      end else if (i == cpm_pkg::CPM_CK_LB && !sync_bypass_in) begin
        fclk_tick[i] <= lb_rise_d; // RULE13 RULE21
      end else begin
        fclk_tick[i] <= fclk_rise[i]; // RULE14 RULE15 RULE20
      end
    end
  end

  assign local_bus_tick = fclk_tick[cpm_pkg::CPM_CK_LB];
  assign reg_bus_tick = fclk_tick[cpm_pkg::CPM_CK_REG];
  assign coproc_tick = fclk_tick[cpm_pkg::CPM_CK_COP];
  assign ocm_tick = fclk_tick[cpm_pkg::CPM_CK_OCM];

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence wake_step_s;
    wake_go ##1 core_zone_clk_en;
  endsequence

  sequence drain_done_s;
    state == cpm_pkg::CPM_DRAIN && core_zone_clk_en && !core_busy;
  endsequence

  core_freeze_a: assert property (!core_zone_clk_en |=> state == $past(state)) // RULE1
    else $error("state moved while core zone stopped");
  timer_alone_a: assert property (
    (!core_zone_clk_en && timer_zone_clk_en && timer_tick_in)
    |=> time_base == $past(time_base) + 1'b1) // RULE2
    else $error("time base idle while core stopped");
  tick_hold_a: assert property (!(timer_zone_clk_en && timer_tick_in)
    |=> time_base == $past(time_base)) // RULE12
    else $error("time base moved without tick");
  wake_order_a: assert property (wake_go |=> (!noncrit_int_en_out && !crit_int_en_out
    && !timer_irq_out && sleep_req_out)) // RULE22
    else $error("status not dropped in wake cycle");
  wake_release_a: assert property (wake_step_s |=> !sleep_req_out) // RULE22
    else $error("sleep request not released after wake");
  drain_sleep_a: assert property ($rose(sleep_req_out)
    |-> $past(wait_state_enable_bit) && !$past(core_busy)) // RULE23
    else $error("sleep requested before drain");
  sleep_enter_a: assert property (drain_done_s |=> sleep_req_out ##0
    state == cpm_pkg::CPM_SLEEP) // RULE19
    else $error("sleep request missing");
  timer_irq_a: assert property ((timer_irq_any && state == cpm_pkg::CPM_RUN && !wake_go)
    |=> timer_irq_out) // RULE17
    else $error("timer irq not shown");
  lb_legacy_a: assert property ((fclk_rise[cpm_pkg::CPM_CK_LB] && sync_bypass_in)
    |=> local_bus_tick) // RULE13
    else $error("bypass tick late");
  lb_full_a: assert property ((fclk_rise[cpm_pkg::CPM_CK_LB] && !sync_bypass_in)
    ##1 !sync_bypass_in |=> local_bus_tick) // RULE21
    else $error("resync tick not two cycles");
  dbg_latch_a: assert property (test_port_zone_clk_en
    |=> debug_sleep_seen == $past(core_clk_inactive_in)) // RULE11
    else $error("clock inactive not latched");

endmodule
`default_nettype wire

// ===== bench/cpm_pwr_model.sv
// fabric power manager model: sleeps the core on request, wakes it on events
`timescale 1ns/1ns
`default_nettype none
module cpm_pwr_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ee_st,
  input wire logic ce_st,
  input wire logic tirq_st,
  input wire logic wdrq_st,
  input wire logic slp_st,
  input wire logic ext_int,
  input wire logic crit_int,
  input wire logic halt,
  input wire logic chip_rst_req,
  input wire logic core_hold,
  input wire logic timer_hold,
  output logic core_en,
  output logic timer_en,
  output logic test_en,
  output logic clk_off
);
  logic ee_q, ce_q, tirq_q, slp_q; // registered status
  logic asleep; // core zone stopped by us
  logic wake; // any wake cause
  // status registered first, so its early drop on wake cannot glitch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {ee_q, ce_q, tirq_q, slp_q} <= 4'h0;
    end else begin
      {ee_q, ce_q, tirq_q, slp_q} <= {ee_st, ce_st, tirq_st, slp_st};
    end
  end
  // wake causes: timer, watchdog, outside reset, enabled interrupts, debug halt
  assign wake = tirq_q | wdrq_st | chip_rst_req | (ext_int & ee_q) | (crit_int & ce_q) | halt;
  // sleep only on a fresh request, wake wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      asleep <= 1'b0;
    end else if (wake) begin
      asleep <= 1'b0;
    end else if (slp_st & !slp_q) begin
      asleep <= 1'b1;
    end
  end
  // sleep by zone enable, main clock keeps running
  assign core_en = !core_hold && asleep !== 1'b1;
  assign clk_off = asleep === 1'b1;
  assign timer_en = !timer_hold;
  assign test_en = 1'b1;
endmodule
`default_nettype wire

// ===== bench/cpm_clk_pwr_if_bench.sv
// self-checking bench of the clock and power management interface
`timescale 1ns/1ns
`default_nettype none
module cpm_clk_pwr_if_bench;
  logic clk = 1'b0;
  logic clk_hold = 1'b0; // partner stops the main clock
  logic arst_n = 1'b0;
  logic core_zone_clk_en, timer_zone_clk_en, test_port_zone_clk_en, core_clk_inactive_in;
  logic timer_tick_in = 1'b0, sync_bypass_in = 1'b1, core_busy = 1'b0;
  logic [3:0] fck = 4'h0; // foreign clocks: local bus, reg bus, coproc, memory
  logic ext_int_in = 1'b0, crit_int_in = 1'b0, debug_halt_in = 1'b0;
  logic msr_wr = 1'b0, msr_wr_ee = 1'b0, msr_wr_ce = 1'b0, msr_wr_we = 1'b0;
  logic pit_load = 1'b0, pit_auto = 1'b0, wdt_rst_en = 1'b0;
  logic [31:0] pit_value = 32'h2;
  logic [1:0] fit_sel = 2'h0, wdt_sel = 2'h0;
  logic [2:0] timer_status_clr = 3'h0;
  logic core_hold = 1'b0, timer_hold = 1'b0; // partner overrides
  logic noncrit_int_en_out, crit_int_en_out, timer_irq_out, watchdog_reset_req_out;
  logic sleep_req_out, local_bus_tick, reg_bus_tick, coproc_tick, ocm_tick;
  logic debug_sleep_seen;
  logic [63:0] time_base;
  logic [31:0] pit_count;
  int failures = 0;
  int checked = 0;
  // status vector polled by index
  wire [7:0] st = {ocm_tick, coproc_tick, reg_bus_tick, local_bus_tick,
                   sleep_req_out, timer_irq_out, crit_int_en_out, noncrit_int_en_out};

  cpm_clk_pwr_if u_dut (
    .clk, .arst_n, .core_zone_clk_en, .timer_zone_clk_en, .test_port_zone_clk_en,
    .core_clk_inactive_in, .timer_tick_in, .sync_bypass_in, .local_bus_clk(fck[0]),
    .reg_bus_clk(fck[1]), .coproc_if_clk(fck[2]), .ocm_clk(fck[3]), .ext_int_in,
    .crit_int_in, .debug_halt_in, .msr_wr, .msr_wr_ee, .msr_wr_ce, .msr_wr_we,
    .core_busy, .pit_load, .pit_value, .pit_auto, .fit_sel, .wdt_sel, .wdt_rst_en,
    .timer_status_clr, .noncrit_int_en_out, .crit_int_en_out, .timer_irq_out,
    .watchdog_reset_req_out, .sleep_req_out, .local_bus_tick, .reg_bus_tick,
    .coproc_tick, .ocm_tick, .debug_sleep_seen, .time_base, .pit_count
  );

  cpm_pwr_model u_pm (
    .clk(clk), .arst_n(arst_n), .ee_st(noncrit_int_en_out), .ce_st(crit_int_en_out),
    .tirq_st(timer_irq_out), .wdrq_st(watchdog_reset_req_out), .slp_st(sleep_req_out),
    .ext_int(ext_int_in), .crit_int(crit_int_in), .halt(debug_halt_in),
    .chip_rst_req(1'b0), .core_hold(core_hold), .timer_hold(timer_hold),
    .core_en(core_zone_clk_en), .timer_en(timer_zone_clk_en),
    .test_en(test_port_zone_clk_en), .clk_off(core_clk_inactive_in)
  );

  // 10 MHz clock, parked high while the partner stops it
  always #50 clk = clk_hold ? 1'b1 : ~clk;

  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // n edges, then settle at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // bounded wait for a status bit
  task automatic wait_for(input int i, input logic v, input int lim, output int n);
    n = 0;
    while (st[i] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (st[i] !== v) begin
      failures++;
      $display("ERROR %0t: wait on status %0d timed out", $time, i);
    end
  endtask

  // one machine-state write
  task automatic msr(input logic ee, input logic ce, input logic we);
    @(posedge clk);
    msr_wr <= 1'b1;
    {msr_wr_ee, msr_wr_ce, msr_wr_we} <= {ee, ce, we};
    @(posedge clk);
    msr_wr <= 1'b0;
    cyc(1);
  endtask

  // one foreign clock rise, returns cycles to its tick
  task automatic fedge(input int i, output int n);
    @(posedge clk);
    fck[i] <= 1'b1;
    @(negedge clk);
    wait_for(4 + i, 1'b1, 10, n);
    cyc(0);
    chk(st[4 + i], 1'b0);
    @(posedge clk);
    fck[i] <= 1'b0;
    cyc(4);
  endtask

  // pulse a timer status clear
  task automatic clr(input logic [2:0] m);
    @(posedge clk);
    timer_status_clr <= m;
    @(posedge clk);
    timer_status_clr <= 3'h0;
    cyc(3);
  endtask

  // counts and verdict
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, well beyond the expected run of under a thousand cycles
  initial begin
    #(100 * 20000);
    failures++;
    $display("ERROR %0t: run did not finish", $time);
    final_report();
  end

  initial begin
    int n0, n1;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    cyc(1);
    chk(st[3:0], 64'h0);
    // timers run with the core stopped, and only with their own enable
    @(posedge clk);
    core_hold <= 1'b1;
    timer_tick_in <= 1'b1;
    repeat (10) @(posedge clk);
    timer_tick_in <= 1'b0;
    timer_hold <= 1'b1;
    cyc(2);
    chk(time_base, 64'ha);
    // main clock stopped high: enabled and ticked timers still hold
    @(posedge clk);
    {timer_hold, timer_tick_in, clk_hold} <= 3'h3;
    #1025;
    chk(clk, 1'b1);
    chk(time_base, 64'ha);
    clk_hold <= 1'b0;
    @(posedge clk);
    timer_hold <= 1'b1;
    timer_tick_in <= 1'b0;
    cyc(1);
    chk(time_base, 64'hb);
    @(posedge clk);
    timer_tick_in <= 1'b1;
    cyc(10);
    chk(time_base, 64'hb);
    // core zone off: writes have no effect
    msr(1'b1, 1'b1, 1'b0);
    chk(st[1:0], 64'h0);
    @(posedge clk);
    {timer_hold, core_hold, timer_tick_in} <= 3'h0;
    for (int k = 0; k < 4; k++) begin
      msr(k[0], k[1], 1'b0);
      chk(st[1:0], k[1:0]);
    end
    // fixed interval event on time-base bit 9
    @(posedge clk);
    timer_tick_in <= 1'b1;
    wait_for(2, 1'b1, 600, n0);
    @(posedge clk);
    timer_tick_in <= 1'b0;
    cyc(1);
    chk(time_base[63:4], 64'h20);
    chk(watchdog_reset_req_out, 1'b0);
    clr(3'h2);
    chk(timer_irq_out, 1'b0);
    // foreign clock ticks, reg bus as reference
    fedge(1, n0);
    chk(n0 inside {[2:5]}, 1'b1);
    fedge(0, n1);
    chk(n1, n0);
    fedge(2, n1);
    chk(n1, n0);
    fedge(3, n1);
    chk(n1, n0);
    @(posedge clk);
    sync_bypass_in <= 1'b0;
    fedge(0, n1);
    chk(n1, n0 + 1);
    // sleep and wake by ext, critical, halt and interval timer
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      core_busy <= 1'b1;
      pit_load <= (k == 3);
      @(posedge clk);
      pit_load <= 1'b0;
      msr(1'b1, 1'b1, 1'b1);
      cyc(4);
      chk(sleep_req_out, 1'b0);
      @(posedge clk);
      core_busy <= 1'b0;
      wait_for(3, 1'b1, 10, n0);
      cyc(3);
      chk({core_clk_inactive_in, debug_sleep_seen}, 64'h3);
      @(posedge clk);
      {debug_halt_in, crit_int_in, ext_int_in} <= 3'h1 << k;
      timer_tick_in <= (k == 3);
      wait_for(0, 1'b0, 30, n0);
      chk({sleep_req_out, crit_int_en_out, timer_irq_out}, 64'h4);
      cyc(0);
      chk(sleep_req_out, 1'b0);
      chk(timer_irq_out, k == 3);
      @(posedge clk);
      {debug_halt_in, crit_int_in, ext_int_in, timer_tick_in} <= 4'h0;
      clr(3'h1);
      chk(pit_count, 64'h0);
    end
    final_report();
  end
endmodule
`default_nettype wire
